// [rtl/ssr_consts.svh]
// Summary of operation
// - Master receive turns off data pin driver
// - Either receive enable starts synchronous reception
// - Single receive clocks exactly one character
// - Single receive bit self-clears after character
// - Continuous clocks; clearing aborts partial character
// - Both set: single clears, continuous continues
// - Sample data on trailing clock edge
// - Completed character sets flag, enters FIFO
// - Data register shows oldest character low byte
// - Flag stays while unread characters remain
// - Slave takes remote clock, driver off
// - Data changes leading edge, one bit/cycle
// - Third character sets overrun, keeps stored two
// - During overrun no characters accepted
// - Single-mode overrun cleared by data read
// - Continuous overrun cleared by enable clear
// - Nine-bit mode shifts nine, shows ninth
// - Receive interrupt when flag and enable
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH
// Register byte offsets
`define SSR_OFS_CTRL   4'h0
`define SSR_OFS_STAT   4'h4
`define SSR_OFS_DATA   4'h8
`define SSR_OFS_BAUD   4'hC
// Control field positions
`define SSR_CTL_EN     0
`define SSR_CTL_SYNC   1
`define SSR_CTL_MST    2
`define SSR_CTL_SINGLE_RECEIVE_ENABLE   3
`define SSR_CTL_CONTINUOUS_RECEIVE_ENABLE   4
`define SSR_CTL_RX9    5
`define SSR_CTL_RECEIVE_INTERRUPT_ENABLE   6
// Baud field positions
`define SSR_BAUD_HIGH_SPEED_BAUD_SELECT  16
`define SSR_BAUD_WIDE_BAUD_GENERATOR_SELECT 17
// Reset values
`define SSR_RST_DIV    16'h0003
// Character lengths
`define SSR_BITS8      4'h8
`define SSR_BITS9      4'h9
`endif

// [rtl/ssr_pkg.sv]
package ssr_pkg;
  // Software control bits
  typedef struct packed {
    logic        receive_interrupt_enable;   // receive_interrupt_enable
    logic        rx9;    // nine_bit_receive_select
    logic        continuous_receive_enable;   // continuous_receive_enable
    logic        single_receive_enable;   // single_receive_enable
    logic        mst;    // clock_source_master_select
    logic        sync;   // synchronous mode
    logic        en;     // port_enable
  } ssr_ctl_t;
  // Baud generator setup
  typedef struct packed {
    logic        wide_baud_generator_select;  // wide_baud_generator_select
    logic        high_speed_baud_select;   // high_speed_baud_select
    logic [15:0] div;    // baud_divisor_high/low
  } ssr_baud_t;
endpackage

// [rtl/ssr_rx.sv]
`timescale 1ns/1ps
`include "ssr_consts.svh"
module ssr_rx (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ck_i,
  output logic             ck_o,
  output logic             ck_oe,
  input  wire logic        rx_i,
  output logic             rx_o,
  output logic             rx_oe,
  output logic             irq_o
);

  // ----------------------------------------
  // Overview
  // ----------------------------------------
  // Receive side of a synchronous serial port.
  // All state sits in one record; one process
  // works out the next record, one registers it.
  // The bus answers after one wait cycle and
  // writes land on the ack edge, so software and
  // the shift engine meet the state in one place.
  // Clock and data pins pass two flops before use.
  // That costs about three system cycles of lag
  // on each sampled bit, so the link clock must
  // run well below the system clock: a divisor
  // below three leaves no settled bit to sample.
  // Reset and port disable both empty the FIFO.

  // ----------------------------------------
  // State record
  // ----------------------------------------
  typedef struct packed {
    ssr_pkg::ssr_ctl_t  ctl;   // Control register
    ssr_pkg::ssr_baud_t baud;  // Baud register
    logic        ck_s1;        // Clock pin sync stage 1
    logic        ck_s2;        // Clock pin sync stage 2
    logic        ck_s3;        // Edge history
    logic        rx_s1;        // Data pin sync stage 1
    logic        rx_s2;        // Data pin sync stage 2
    logic        ck;           // Driven shift clock
    logic        ck_oe;        // Clock driver enable
    logic [15:0] hcnt;         // Half period counter
    logic [3:0]  bits;         // Bits in shift register
    logic [8:0]  sr;           // receive_shift_register
    logic [1:0][8:0] fifo;     // Entry 0 is oldest
    logic [1:0]  cnt;          // Unread characters
    logic        ovr;          // overrun_error_flag
    logic        ovr_cr;       // Overrun in continuous
    logic        ack;          // Bus answer
    logic [31:0] dat;          // Bus read data
    logic        irq;          // Interrupt request
  } ssr_state_t;

  ssr_state_t q;  // Registered state
  ssr_state_t d;  // Next state

  // Helper terms, visible to checks
  logic        run;       // Reception may proceed
  logic        smp;       // Trailing edge this cycle
  logic        done;      // Character completes
  logic        pop;       // Data register read
  logic        acc;       // Bus access at ack edge
  logic [3:0]  nb;        // Character length
  logic [15:0] lim;       // Half period limit
  logic [8:0]  nsr;       // Shift register after sample
  logic [8:0]  chr;       // Finished character

  // ----------------------------------------
  // Next state logic
  // ----------------------------------------
  // Every field keeps its value unless a branch
  // below says otherwise; later branches win, which
  // gives set-over-clear and disable-over-all.
  // Helper terms get a value first, on every path.
  always_comb begin
    d     = q;
    smp   = 1'b0;
    done  = 1'b0;
    nsr   = q.sr;
    chr   = 9'h000;
    acc   = wb_cyc_i & wb_stb_i & q.ack;
    pop   = acc & ~wb_we_i
            & (wb_adr_i == `SSR_OFS_DATA);
    nb    = q.ctl.rx9 ? `SSR_BITS9 : `SSR_BITS8;
    // Eight bit generator only sees low byte
    lim   = q.baud.wide_baud_generator_select ? q.baud.div
                         : {8'h00, q.baud.div[7:0]};
    // Pin synchronisers; stage 1 feeds stage 2 only
    d.ck_s1 = ck_i;
    d.ck_s2 = q.ck_s1;
    d.ck_s3 = q.ck_s2;
    d.rx_s1 = rx_i;
    d.rx_s2 = q.rx_s1;

    // Read data is latched in the wait cycle so
    // that it stands, registered, in the ack cycle
    // Bus: one wait cycle, ack drops after one
    d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
    d.dat = 32'h0000_0000;
    if (wb_cyc_i & wb_stb_i & ~q.ack & ~wb_we_i) begin
      case (wb_adr_i)
        `SSR_OFS_CTRL: d.dat = {25'h0000000, q.ctl};
        `SSR_OFS_STAT: begin
          d.dat[0]   = (q.cnt != 2'h0);
          d.dat[1]   = q.ovr;
          d.dat[2]   = q.fifo[0][8];
          d.dat[5:4] = q.cnt;
        end
        `SSR_OFS_DATA: d.dat = {24'h000000,
                                q.fifo[0][7:0]};
        `SSR_OFS_BAUD: d.dat = {14'h0000, q.baud};
        default:       d.dat = 32'h0000_0000;
      endcase
    end

    // Only lane 0 matters for control; stray lanes
    // are ignored rather than refused
    // Writes land at the ack edge
    if (acc & wb_we_i) begin
      case (wb_adr_i)
        `SSR_OFS_CTRL: begin
          if (wb_sel_i[0]) begin
            d.ctl = wb_dat_i[6:0];
          end
        end
        `SSR_OFS_BAUD: begin
          if (wb_sel_i[0]) begin
            d.baud.div[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            d.baud.div[15:8] = wb_dat_i[15:8];
          end
          if (wb_sel_i[2]) begin
            d.baud.high_speed_baud_select  = wb_dat_i[`SSR_BAUD_HIGH_SPEED_BAUD_SELECT];
            d.baud.wide_baud_generator_select = wb_dat_i[`SSR_BAUD_WIDE_BAUD_GENERATOR_SELECT];
          end
        end
        default: ;
      endcase
    end

    // Pop comes before push, so a read and a
    // finishing character in one cycle keep both
    // Read pops oldest, next moves to top
    if (pop && q.cnt != 2'h0) begin
      d.fifo[0] = q.fifo[1];
      d.cnt     = q.cnt - 2'h1;
    end
    // Single-mode overrun clears on data read
    if (pop && q.ovr && !q.ovr_cr) begin
      d.ovr = 1'b0;
    end
    // Continuous overrun clears with enable
    if (q.ovr && q.ovr_cr && !d.ctl.continuous_receive_enable) begin
      d.ovr = 1'b0;
    end

    // Overrun freezes the engine but keeps the FIFO
    // readable until software clears the condition
    // Either enable starts reception; overrun stalls it
    run = q.ctl.en & q.ctl.sync & ~q.ovr
          & (q.ctl.single_receive_enable | q.ctl.continuous_receive_enable);

    // Master counts half periods of lim + 1 cycles;
    // slave only watches the synchronised pin
    if (q.ctl.mst) begin
      // Master: divider drives clock, idle low
      if (run) begin
        if (q.hcnt >= lim) begin
          d.hcnt = 16'h0000;
          d.ck   = ~q.ck;
          smp    = q.ck;  // Falling is trailing
        end else begin
          d.hcnt = q.hcnt + 16'h0001;
        end
      end else begin
        d.hcnt = 16'h0000;
        d.ck   = 1'b0;
      end
    end else begin
      // Slave: remote clock, trailing edge found
      d.ck   = 1'b0;
      d.hcnt = 16'h0000;
      smp    = run & q.ck_s3 & ~q.ck_s2;
    end

    // Synchronised data lags the pin; the peer must
    // hold each bit a few cycles before the fall
    // Sample data on trailing edge
    if (smp) begin
      nsr    = {q.rx_s2, q.sr[8:1]};
      d.sr   = nsr;
      d.bits = q.bits + 4'h1;
      if (d.bits == nb) begin
        done = 1'b1;
      end
    end

    // Eight bit characters sit one place high in
    // the shift register, so they are moved down
    if (done) begin
      chr    = q.ctl.rx9 ? nsr : {1'b0, nsr[8:1]};
      d.bits = 4'h0;
      d.ctl.single_receive_enable = 1'b0;
      if (d.cnt == 2'h2) begin
        // Full: flag error, keep both stored
        d.ovr    = 1'b1;
        d.ovr_cr = q.ctl.continuous_receive_enable;
      end else begin
        d.fifo[d.cnt] = chr;
        d.cnt         = d.cnt + 2'h1;
      end
    end

    // A write that keeps single receive set is not
    // an abort: that character still finishes
    // Continuous cleared mid-character: abort
    if (q.ctl.continuous_receive_enable && !d.ctl.continuous_receive_enable && !d.ctl.single_receive_enable) begin
      d.bits = 4'h0;
      d.ck   = 1'b0;
      d.hcnt = 16'h0000;
    end

    // Disable beats every other update, stored
    // characters included
    // Port disable resets the receive side
    if (!d.ctl.en) begin
      d.bits   = 4'h0;
      d.cnt    = 2'h0;
      d.ovr    = 1'b0;
      d.ovr_cr = 1'b0;
      d.ck     = 1'b0;
      d.hcnt   = 16'h0000;
    end

    // Clock driven only as enabled master
    d.ck_oe = d.ctl.en & d.ctl.sync & d.ctl.mst;
    // Request while characters wait and enabled
    d.irq = (d.cnt != 2'h0) & d.ctl.receive_interrupt_enable;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Reset clears all; the divisor starts at a value
  // that still leaves each sampled bit settled
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q          <= '0;
      q.baud.div <= `SSR_RST_DIV;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Each output is a field of the state record
  // or a constant, so none of them can glitch
  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign ck_o     = q.ck;
  assign ck_oe    = q.ck_oe;
  // Data pin is input only in every receive mode
  assign rx_o     = 1'b0;
  assign rx_oe    = 1'b0;
  assign irq_o    = q.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Checks watch the state record and the helper
  // terms; each one names the rule it guards.
  // Covers mark the main receive scenarios.
  // Checks stay quiet while reset is applied.

  // Data pin never driven by this block in master mode
  a_rx_drv_off: assert property (
    q.ctl.mst |-> !rx_oe)
    else $error("data pin driven in master receive");

  // Clock driver off whenever the stored mode bit says slave
  a_ck_slave_off: assert property (
    !q.ctl.mst |-> !ck_oe)
    else $error("clock driven as slave");

  // Single receive ends with its character
  a_single_receive_enable_clear: assert property (
    done |=> !q.ctl.single_receive_enable)
    else $error("single enable not cleared");

  // Both enables set: continuous carries on
  a_continuous_receive_enable_keep: assert property (
    done && q.ctl.continuous_receive_enable && q.ctl.single_receive_enable && !acc
    |=> q.ctl.continuous_receive_enable && !q.ctl.single_receive_enable)
    else $error("continuous mode not kept");

  // Third character flags and leaves FIFO alone
  a_ovr_keep: assert property (
    done && q.cnt == 2'h2 && !pop && q.ctl.en
    |=> q.ovr && q.cnt == 2'h2 && $stable(q.fifo))
    else $error("overrun lost or data changed");

  // Count never grows while overrun stands
  a_ovr_block: assert property (
    q.ovr |=> q.cnt <= $past(q.cnt))
    else $error("character taken during overrun");

  // Clearing continuous drops the partial bits
  a_continuous_receive_enable_abort: assert property (
    q.ctl.continuous_receive_enable && !d.ctl.continuous_receive_enable && !d.ctl.single_receive_enable
    |=> q.bits == 4'h0 && !q.ck)
    else $error("partial character not discarded");

  // Read moves the second character to the top
  a_pop_next: assert property (
    pop && q.cnt == 2'h2 && !done
    |=> q.cnt == 2'h1 && q.fifo[0] == $past(q.fifo[1]))
    else $error("pop did not advance");

  // Request follows a waiting character
  a_irq_flag: assert property (
    q.cnt != 2'h0 && q.ctl.receive_interrupt_enable && q.ctl.en
    && !acc |=> irq_o)
    else $error("interrupt not raised");

  // Disabled port holds nothing
  a_dis_reset: assert property (
    !q.ctl.en |-> q.cnt == 2'h0 && !q.ovr)
    else $error("disabled port holds state");

  // Finished character lands at the top
  a_push_flag: assert property (
    done && q.cnt == 2'h0 && q.ctl.en && !acc
    |=> q.cnt == 2'h1 && q.fifo[0] == $past(chr))
    else $error("character not stored");

  // Clock rests low whenever reception may not run
  a_ck_idle: assert property (
    !run |=> !ck_o)
    else $error("shift clock moved while stopped");

  // No sample lands while overrun is flagged
  a_ovr_stall: assert property (
    q.ovr |-> !smp)
    else $error("sample taken during overrun");

  // Master samples only as its clock falls
  a_rx_fall: assert property (
    smp && q.ctl.mst |-> q.ck)
    else $error("sample off the trailing edge");

  // Single-mode overrun goes with the data read
  a_ovr_clear: assert property (
    pop && q.ovr && !q.ovr_cr |=> !q.ovr)
    else $error("overrun kept after data read");

  c_single: cover property (done && !q.ctl.continuous_receive_enable);
  c_cont:   cover property (done && q.ctl.continuous_receive_enable);
  c_ovr:    cover property ($rose(q.ovr));
  c_nine:   cover property (done && q.ctl.rx9);
  c_slave:  cover property (done && !q.ctl.mst);

endmodule

// [verif/ssr_peer.sv]
`timescale 1ns/1ps
// ----
// Remote peer on the shift clock and data lines
// ----
module ssr_peer (
  input  wire logic       clk_sys,
  input  wire logic       ck_line, // Clock pin level
  input  wire logic       load,    // Restart at bit 0
  input  wire logic [8:0] word,    // Character, LSB first
  input  wire logic [3:0] nb,      // Bits per character
  input  wire logic [3:0] nclk,    // Clocks to make, 0 none
  output logic            ck_gen,  // Our clock, idle low
  output logic            rx       // Data line
);
  logic       ck_p;  // Last clock level
  logic [3:0] idx;   // Next bit out
  logic [3:0] left;  // Clocks still owed
  logic [1:0] ph;    // Half period, 4 cycles
  logic [1:0] hold;  // Hold time left
  initial begin
    {ck_p, ck_gen, rx, idx, left, ph, hold} = '0;
  end
  // Clock only within frames; data released after hold
  always @(posedge clk_sys) begin
    ck_p <= ck_line;
    if (load) begin
      idx  <= 4'h0;
      left <= nclk;
    end else if (left != 4'h0) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3)
        ck_gen <= !ck_gen;
      if (ph == 2'h3 && ck_gen)
        left <= left - 4'h1; // One clock counted at each fall
    end
    if (ck_line && !ck_p) begin // New bit on leading edge
      rx   <= word[idx];
      idx  <= (idx + 4'h1 == nb) ? 4'h0 : idx + 4'h1;
      hold <= 2'h0;
    end else if (!ck_line && ck_p)
      hold <= 2'h2;
    else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
      if (hold == 2'h1)
        rx <= !rx; // Stale level never lingers
    end
  end
endmodule

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
  logic        clk_sys, sys_rst;    // Clock, reset
  logic        cyc, stb, we;        // Bus request
  logic [3:0]  adr;                 // Byte address
  logic [31:0] wdat, rdat, dat_o;   // Bus data
  logic        ack, ck_o, ck_oe;
  logic        rx_o, rx_oe, irq_o;
  logic        load, ck_gen, rx, ck_q;
  logic [8:0]  word;                // Peer character
  logic [3:0]  nb, nclk;            // Peer bits, clocks
  int          rises = 0;           // Our clock rises
  int          n_errors, num_checks;
  wire         ck_line = ck_oe ? ck_o : ck_gen; // Shared pin

  ssr_rx dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .ck_i(ck_line),
    .ck_o(ck_o), .ck_oe(ck_oe), .rx_i(rx), .rx_o(rx_o), .rx_oe(rx_oe),
    .irq_o(irq_o));
  ssr_peer u_peer (.clk_sys(clk_sys), .ck_line(ck_line), .load(load),
    .word(word), .nb(nb), .nclk(nclk), .ck_gen(ck_gen), .rx(rx));

  // ----
  // Clock and edge counting
  // ----
  always #50 clk_sys = !clk_sys;
  always @(posedge clk_sys) begin
    ck_q <= ck_o;
    if (ck_o && !ck_q)
      rises <= rises + 1;
  end

  // ----
  // Shared tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    $display("[FAIL] wait timed out");
    final_report();
  endtask
  // Classic cycle: hold until ack is sampled
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    {cyc, stb} <= 2'h0;
    if (n >= 20)
      hang();
  endtask
  task automatic rd(input string nm, input logic [3:0] a,
                    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask
  task automatic send(input logic [8:0] w, input logic [3:0] n, c);
    @(posedge clk_sys);
    {load, word, nb, nclk} <= {1'b1, w, n, c};
    @(posedge clk_sys);
    load <= 1'b0;
  endtask
  // Wait for clock rises, then let the last bit land
  task automatic upto(input int n);
    int k;
    for (k = 0; k < 3000 && rises < n; k++)
      @(posedge clk_sys);
    if (rises < n)
      hang();
    repeat (20) @(posedge clk_sys);
  endtask
  task automatic until_stat(input int b);
    int k;
    k = 0;
    do begin
      bus(1'b0, 4'h4, 32'h0);
      k++;
    end while (rdat[b] !== 1'b1 && k < 300);
    if (rdat[b] !== 1'b1)
      hang();
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_single();
    int r0;
    bus(1'b1, 4'hC, 32'h3);           // Divisor first
    rd("baud", 4'hC, 32'h3);
    send(9'h0A5, 4'h8, 4'h0);
    r0 = rises;
    bus(1'b1, 4'h0, 32'hF);
    chk("rx_oe", 32'h0, {31'h0, rx_oe});
    upto(r0 + 8);
    chk("clocks", 32'h8, 32'(rises - r0));
    rd("ctrl", 4'h0, 32'h7);
    rd("stat", 4'h4, 32'h11);
    rd("data", 4'h8, 32'hA5);
    rd("stat", 4'h4, 32'h0);
    $display("single receive done");
  endtask
  task automatic t_overrun();
    logic [8:0] ws [3] = '{9'h1A5, 9'h03C, 9'h1FF};
    int r0;
    r0 = rises;
    for (int i = 0; i < 3; i++) begin
      send(ws[i], 4'h9, 4'h0);
      bus(1'b1, 4'h0, 32'h6F);
      upto(r0 + 9 * (i + 1));
    end
    chk("irq", 32'h1, {31'h0, irq_o});
    bus(1'b1, 4'h0, 32'h6F);
    repeat (4) @(posedge clk_sys);
    r0 = rises;
    repeat (40) @(posedge clk_sys);
    chk("held", 32'(r0), 32'(rises));
    bus(1'b1, 4'h0, 32'h67);
    rd("stat", 4'h4, 32'h27);
    rd("data", 4'h8, 32'hA5);
    rd("stat", 4'h4, 32'h11);
    rd("data", 4'h8, 32'h3C);
    rd("stat", 4'h4, 32'h0);
    $display("overrun done");
  endtask
  task automatic t_cont();
    int r0;
    send(9'h05A, 4'h8, 4'h0);
    r0 = rises;
    bus(1'b1, 4'h0, 32'h1F);
    upto(r0 + 11);
    rd("ctrl", 4'h0, 32'h17);
    bus(1'b1, 4'h0, 32'h07);
    repeat (4) @(posedge clk_sys);
    r0 = rises;
    repeat (40) @(posedge clk_sys);
    chk("stopped", 32'(r0), 32'(rises));
    rd("stat", 4'h4, 32'h11);
    rd("data", 4'h8, 32'h5A);
    bus(1'b1, 4'h0, 32'h17);
    until_stat(1);
    rd("stat", 4'h4, 32'h23);
    bus(1'b1, 4'h0, 32'h07);
    rd("stat", 4'h4, 32'h21);
    bus(1'b1, 4'h0, 32'h0);
    rd("stat", 4'h4, 32'h0);
    $display("continuous done");
  endtask
  task automatic t_slave();
    bus(1'b1, 4'h0, 32'h13);
    send(9'h0C3, 4'h8, 4'h8);
    chk("ck_oe", 32'h0, {31'h0, ck_oe});
    until_stat(0);
    rd("data", 4'h8, 32'hC3);
    bus(1'b1, 4'h0, 32'h0);
    $display("slave done");
  endtask

  initial begin
    {clk_sys, cyc, stb, we, adr, wdat} = '0;
    {load, word, nb, nclk, ck_q} = '0;
    n_errors = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_single();
    t_overrun();
    t_cont();
    t_slave();
    final_report();
  end
endmodule
